// File: design/irr_pkg.sv
// constants shared by the remote-control receiver front end
// assumes one 100 MHz cycle clock and an apb master using 32-bit data
//
// Contract
// - guide width setup is ignored in formats 2 and 3
// - zero-width setup defines expected logic-0 pulse width and timings one, two
// - one-width setup defines expected logic-1 pulse width and timings three, four
// - high-bits setup gives width msbs and the shift load direction
// - width counter is a 5-bit up-counter stepped by prescaler count clock
// - input sampled each base clock; level accepted after four equal samples
// - rejection width within one base clock below four base clocks
// - run bit 7 clear stops receiver; set starts and waits for signal
// - format field selects guide kind, ppm or manchester, stop bit (the code decodes no stop bit)
// - input already active at start counts as detected start edge
// - base clock select: 4..128 cycles, subclock for 6, one cycle for 7
// - in crystal hold the receiver runs only on the subclock source
// - wake from crystal hold only if started with subclock base clock
// - guide-ok flag set on valid guide in formats 0, 1, 4; sticky
// - guide enable and guide-ok together raise wake and interrupt request
// - prescaler divides base clock by format- and phase-dependent selected count
package irr_pkg;

  // ********************************************************
  // register indices (byte address is four times the index)
  // ********************************************************
  localparam logic [15:0] IRR_IDX_CONTROL = 16'hfec7;
  localparam logic [15:0] IRR_IDX_INTERRUPT = 16'hfec8;
  localparam logic [15:0] IRR_IDX_PRESCALE = 16'hfecb;
  localparam logic [15:0] IRR_IDX_GUIDE_W = 16'hfecc;
  localparam logic [15:0] IRR_IDX_ZERO_W = 16'hfecd;
  localparam logic [15:0] IRR_IDX_ONE_W = 16'hfece;
  localparam logic [15:0] IRR_IDX_HIGH_W = 16'hfecf;
  localparam logic [15:0] IRR_IDX_STATUS = 16'hfed0;
  localparam int IRR_ADDR_W = 18;

  // ********************************************************
  // field positions
  // ********************************************************
  localparam int IRR_RUN_BIT = 7;
  localparam int IRR_FMT_LSB = 4;
  localparam int IRR_POL_BIT = 3;
  localparam int IRR_CKSEL_LSB = 0;
  localparam int IRR_GOK_BIT = 7;
  localparam int IRR_GIE_BIT = 6;
  localparam int IRR_GPR_LSB = 6;
  localparam int IRR_DPR_LSB = 4;
  localparam int IRR_DIR_BIT = 7;

  // ********************************************************
  // reset values
  // ********************************************************
  localparam logic [7:0] IRR_RST_CONTROL = 8'h00;
  localparam logic [7:0] IRR_RST_INTERRUPT = 8'h00;
  localparam logic [7:0] IRR_RST_SETUP = 8'h00;
  localparam logic [6:0] IRR_RST_HIGH_W = 7'h00;

  // ********************************************************
  // codes and timing counts
  // ********************************************************
  localparam logic [2:0] IRR_CK_SUB = 3'h6;
  localparam logic [2:0] IRR_CK_ONE = 3'h7;
  localparam logic [7:0] IRR_CK_BASE_DIV = 8'h04;
  localparam int IRR_FILTER_SAMPLES = 4;
  localparam logic [5:0] IRR_PPM_PRE_BASE = 6'h04;
  localparam logic [5:0] IRR_MAN_PRE_BASE = 6'h02;

  typedef enum logic [2:0] {
    IRR_FMT_A, IRR_FMT_B, IRR_FMT_C, IRR_FMT_D, IRR_FMT_E
  } irr_fmt_type;

  typedef enum {
    IRR_ST_STOP, IRR_ST_WAIT, IRR_ST_G_ACT, IRR_ST_G_IDLE, IRR_ST_DATA
  } irr_state_type;

  // formats that carry a guide pulse
  function automatic logic irr_has_guide(input logic [2:0] fmt);
    irr_has_guide = (fmt == 3'h0) || (fmt == 3'h1) || (fmt == 3'h4);
  endfunction

  // formats that use manchester coding
  function automatic logic irr_is_manchester(input logic [2:0] fmt);
    irr_is_manchester = (fmt == 3'h3) || (fmt == 3'h4);
  endfunction

endpackage

// File: design/irr_noise_filter.sv
// noise filter for the synchronised remote input
// assumes sample_in already passed two flip-flops and tick_in is a base clock pulse
`timescale 1ns/1ps
`default_nettype none
module irr_noise_filter
  import irr_pkg::*;
(
  // clock and reset
  input wire logic clock_in,
  input wire logic sys_rst_in,
  // control
  input wire logic clear_in,
  input wire logic clear_level_in,
  input wire logic tick_in,
  input wire logic sample_in,
  // filtered level
  output logic level_out
);

  logic [IRR_FILTER_SAMPLES-2:0] hist_ff;
  logic level_ff;
  logic all_new;

  // the newest sample plus three older ones must all differ from the held level
  assign all_new = (hist_ff == {(IRR_FILTER_SAMPLES-1){~level_ff}}) && (sample_in != level_ff);

  // shifting history; a pulse of three ticks or fewer never moves the level
  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in || clear_in)
    begin
      hist_ff <= '0;
      level_ff <= 1'b0;
      if (clear_in && !sys_rst_in)
      begin
        hist_ff <= {(IRR_FILTER_SAMPLES-1){clear_level_in}};
        level_ff <= clear_level_in;
      end
    end
    else if (tick_in)
    begin
      hist_ff <= {hist_ff[IRR_FILTER_SAMPLES-3:0], sample_in};
      if (all_new)
        level_ff <= sample_in;
    end
  end

  assign level_out = level_ff;

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (sys_rst_in || clear_in);

  filt_accept_a: assert property (tick_in && all_new |=> level_ff == $past(sample_in))
    else $error("filter did not accept four equal samples");
  filt_hold_a: assert property (!tick_in |=> $stable(level_ff))
    else $error("filter level moved without a base tick");

endmodule
`default_nettype wire

// File: design/irr_width_counter.sv
// prescaler and 5-bit pulse width counter
// assumes tick_in is a one-cycle base clock pulse
`timescale 1ns/1ps
`default_nettype none
module irr_width_counter
  import irr_pkg::*;
#(
  parameter int WIDTH = 5
)
(
  // clock and reset
  input wire logic clock_in,
  input wire logic sys_rst_in,
  // control
  input wire logic clear_in,
  input wire logic tick_in,
  input wire logic manchester_in,
  input wire logic [1:0] pre_sel_in,
  // measured width
  output logic [WIDTH-1:0] width_out
);

  logic [5:0] pre_ff;
  logic [WIDTH-1:0] width_ff;
  logic [5:0] pre_len;
  logic step;

  // 4..32 base clocks for ppm, half of it for manchester
  assign pre_len = (manchester_in ? IRR_MAN_PRE_BASE : IRR_PPM_PRE_BASE) << pre_sel_in;
  assign step = tick_in && (pre_ff == pre_len - 6'h01);

  // prescaler wraps on its selected length
  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in || clear_in)
      pre_ff <= '0;
    else if (tick_in)
      pre_ff <= step ? 6'h00 : pre_ff + 6'h01;
  end

  // saturates so a long pulse never reads as a short one
  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in || clear_in)
      width_ff <= '0;
    else if (step && (width_ff != '1))
      width_ff <= width_ff + 1'b1;
  end

  assign width_out = width_ff;

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (sys_rst_in || clear_in);

  // a clear in the previous cycle also moves the count, back to zero
  width_step_a: assert property ($changed(width_ff) && !$past(clear_in) && !$past(sys_rst_in)
    |-> $past(step) && width_ff == $past(width_ff) + 1'b1)
    else $error("width counter moved without a count clock");
  pre_len_a: assert property (step |-> pre_ff == pre_len - 6'h01 && tick_in)
    else $error("count clock at wrong prescaler count");

endmodule
`default_nettype wire

// File: design/irr_receiver.sv
// remote-control receiver front end: apb registers, base clock, filter,
// width measurement, guide detection and data pulse classification
// assumes an apb master on clock_in and an asynchronous remote input pin
//
// Local design decision: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module irr_receiver
  import irr_pkg::*;
(
  // clock and reset
  input wire logic clock_in,
  input wire logic sys_rst_in,
  // apb slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [IRR_ADDR_W-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // remote input and subclock source
  input wire logic remote_pin_in,
  input wire logic subclock_in,
  // crystal hold state of the core
  input wire logic xtal_hold_in,
  // interrupt and wake
  output logic irq_out,
  output logic hold_release_out,
  // shift load direction for the data path
  output logic load_direction_out
);

  // ********************************************************
  // registers
  // ********************************************************
  logic [7:0] control_ff;
  logic guide_ok_ff;
  logic guide_ie_ff;
  logic [3:0] prescale_ff;
  logic [7:0] guide_w_ff;
  logic [7:0] zero_w_ff;
  logic [7:0] one_w_ff;
  logic [6:0] high_w_ff;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic irq_ff;
  logic wake_ff;
  logic sub_start_ff;
  logic bit_valid_ff;
  logic bit_value_ff;
  logic bit_err_ff;
  logic [4:0] width;
  irr_state_type state_ff;
  irr_state_type nxt_state;

  logic run;
  logic [2:0] fmt;
  logic [2:0] ck_sel;
  logic wr_en;
  logic rd_setup;
  logic [15:0] idx;
  logic guide_set;
  logic gok_wr0;

  assign run = control_ff[IRR_RUN_BIT];
  assign fmt = control_ff[IRR_FMT_LSB +: 3];
  assign ck_sel = control_ff[IRR_CKSEL_LSB +: 3];
  assign idx = paddr_in[17:2];
  assign rd_setup = psel_in && !penable_in;
  assign wr_en = psel_in && penable_in && pready_ff && pwrite_in && !pslverr_ff;

  // ********************************************************
  // apb slave
  // ********************************************************

  // index decode; byte lanes are the low bits
  function automatic logic idx_known(input logic [15:0] i, input logic [1:0] lo);
    idx_known = (lo == 2'b00) && ((i == IRR_IDX_CONTROL) || (i == IRR_IDX_INTERRUPT) ||
      (i == IRR_IDX_PRESCALE) || (i == IRR_IDX_GUIDE_W) || (i == IRR_IDX_ZERO_W) ||
      (i == IRR_IDX_ONE_W) || (i == IRR_IDX_HIGH_W) || (i == IRR_IDX_STATUS));
  endfunction

  function automatic logic [7:0] read_mux(input logic [15:0] i);
    read_mux = 8'h00;
    if (i == IRR_IDX_CONTROL)
      read_mux = control_ff;
    else if (i == IRR_IDX_INTERRUPT)
      read_mux = {guide_ok_ff, guide_ie_ff, 6'h00};
    else if (i == IRR_IDX_PRESCALE)
      read_mux = {prescale_ff, 4'h0};
    else if (i == IRR_IDX_GUIDE_W)
      read_mux = guide_w_ff;
    else if (i == IRR_IDX_ZERO_W)
      read_mux = zero_w_ff;
    else if (i == IRR_IDX_ONE_W)
      read_mux = one_w_ff;
    else if (i == IRR_IDX_HIGH_W)
      read_mux = {high_w_ff[6], 1'b0, high_w_ff[5:0]};
    else if (i == IRR_IDX_STATUS)
      read_mux = {bit_err_ff, bit_value_ff, bit_valid_ff, width[4:0]};
  endfunction

  // answer in the first access cycle; no wait states
  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in)
    begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= '0;
    end
    else
    begin
      pready_ff <= rd_setup;
      pslverr_ff <= rd_setup && !idx_known(idx, paddr_in[1:0]);
      if (rd_setup)
        prdata_ff <= idx_known(idx, paddr_in[1:0]) ? {24'h000000, read_mux(idx)} : 32'h0;
    end
  end

  // configuration writes; software keeps run clear while changing them
  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in)
    begin
      control_ff <= IRR_RST_CONTROL;
      guide_ie_ff <= IRR_RST_INTERRUPT[IRR_GIE_BIT];
      prescale_ff <= IRR_RST_SETUP[7:4];
      guide_w_ff <= IRR_RST_SETUP;
      zero_w_ff <= IRR_RST_SETUP;
      one_w_ff <= IRR_RST_SETUP;
      high_w_ff <= IRR_RST_HIGH_W;
    end
    else if (wr_en)
    begin
      if (idx == IRR_IDX_CONTROL)
        control_ff <= pwdata_in[7:0];
      if (idx == IRR_IDX_INTERRUPT)
        guide_ie_ff <= pwdata_in[IRR_GIE_BIT];
      if (idx == IRR_IDX_PRESCALE)
        prescale_ff <= pwdata_in[7:4];
      if (idx == IRR_IDX_GUIDE_W)
        guide_w_ff <= pwdata_in[7:0];
      if (idx == IRR_IDX_ZERO_W)
        zero_w_ff <= pwdata_in[7:0];
      if (idx == IRR_IDX_ONE_W)
        one_w_ff <= pwdata_in[7:0];
      if (idx == IRR_IDX_HIGH_W)
        high_w_ff <= {pwdata_in[7], pwdata_in[5:0]};
    end
  end

  assign gok_wr0 = wr_en && (idx == IRR_IDX_INTERRUPT) && !pwdata_in[IRR_GOK_BIT];

  // sticky guide flag; a detection in the clearing cycle wins
  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in)
      guide_ok_ff <= IRR_RST_INTERRUPT[IRR_GOK_BIT];
    else if (guide_set)
      guide_ok_ff <= 1'b1;
    else if (gok_wr0)
      guide_ok_ff <= 1'b0;
  end

  // ********************************************************
  // base clock
  // ********************************************************
  logic [1:0] sub_sync_ff;
  logic sub_last_ff;
  logic [7:0] div_ff;
  logic base_tick;
  logic [7:0] div_len;

  // cycle-clock divisor for codes 0 to 5
  function automatic logic [7:0] base_div(input logic [2:0] sel);
    base_div = IRR_CK_BASE_DIV << sel;
  endfunction

  // subclock comes from another oscillator, so it is synchronised first
  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in)
    begin
      sub_sync_ff <= '0;
      sub_last_ff <= 1'b0;
    end
    else
    begin
      sub_sync_ff <= {sub_sync_ff[0], subclock_in};
      sub_last_ff <= sub_sync_ff[1];
    end
  end

  assign div_len = base_div(ck_sel);

  // cycle clock halts in crystal hold, only the subclock keeps going
  always_comb
  begin
    if (!run)
      base_tick = 1'b0;
    else if (ck_sel == IRR_CK_SUB)
      base_tick = sub_sync_ff[1] && !sub_last_ff;
    else if (xtal_hold_in)
      base_tick = 1'b0;
    else if (ck_sel == IRR_CK_ONE)
      base_tick = 1'b1;
    else
      base_tick = (div_ff == div_len - 8'h01);
  end

  // free divider, restarted on every stop
  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in || !run || xtal_hold_in)
      div_ff <= '0;
    else
      div_ff <= (div_ff == div_len - 8'h01) ? 8'h00 : div_ff + 8'h01;
  end

  // ********************************************************
  // input path
  // ********************************************************
  logic [1:0] pin_sync_ff;
  logic filt_level;
  logic active;
  logic active_last_ff;
  logic rise;
  logic fall;
  logic start;
  logic meas_clear;
  logic [1:0] pre_sel;

  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in)
      pin_sync_ff <= '0;
    else
      pin_sync_ff <= {pin_sync_ff[0], remote_pin_in};
  end

  // stopped filter rests at the idle level, so active input at start is an edge
  irr_noise_filter u_filter (
    .clock_in(clock_in),
    .sys_rst_in(sys_rst_in),
    .clear_in(!run),
    .clear_level_in(control_ff[IRR_POL_BIT]),
    .tick_in(base_tick),
    .sample_in(pin_sync_ff[1]),
    .level_out(filt_level)
  );

  assign active = filt_level ^ control_ff[IRR_POL_BIT];
  assign start = run && (state_ff == IRR_ST_STOP);

  // an input already active when run rises shows as a rise once the filter accepts it
  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in || !run)
      active_last_ff <= 1'b0;
    else
      active_last_ff <= active;
  end

  assign rise = active && (!active_last_ff || start);
  assign fall = !active && active_last_ff;
  assign pre_sel = (state_ff == IRR_ST_DATA) ? prescale_ff[IRR_DPR_LSB-4 +: 2]
    : prescale_ff[IRR_GPR_LSB-4 +: 2];
  assign meas_clear = !run || rise || fall;

  irr_width_counter #(
    .WIDTH(5)
  ) u_width (
    .clock_in(clock_in),
    .sys_rst_in(sys_rst_in),
    .clear_in(meas_clear),
    .tick_in(base_tick),
    .manchester_in(irr_is_manchester(fmt)),
    .pre_sel_in(pre_sel),
    .width_out(width)
  );

  // ********************************************************
  // receive sequencing
  // ********************************************************
  logic [4:0] guide_act_w;
  logic [4:0] guide_idle_w;
  logic [4:0] zero_w;
  logic [4:0] one_w;

  // msb from the high-bits register, low bits from a setup nibble (guide active width uses the upper nibble)
  assign guide_act_w = {high_w_ff[1], guide_w_ff[7:4]};
  assign guide_idle_w = {high_w_ff[0], guide_w_ff[3:0]};
  assign zero_w = {high_w_ff[2], zero_w_ff[3:0]};
  assign one_w = {high_w_ff[4], one_w_ff[3:0]};
  assign guide_set = (state_ff == IRR_ST_G_IDLE && rise && width >= guide_idle_w)
    || (state_ff == IRR_ST_G_ACT && fall && fmt == 3'h0 && width >= guide_act_w);

  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      IRR_ST_STOP:
        nxt_state = IRR_ST_WAIT;
      IRR_ST_WAIT:
        if (rise)
          nxt_state = irr_has_guide(fmt) ? IRR_ST_G_ACT : IRR_ST_DATA;
      IRR_ST_G_ACT:
        if (fall)
        begin
          if (width < guide_act_w)
            nxt_state = IRR_ST_WAIT;
          else if (fmt == 3'h0)
            nxt_state = IRR_ST_DATA;
          else
            nxt_state = IRR_ST_G_IDLE;
        end
      IRR_ST_G_IDLE:
        if (rise)
          nxt_state = (width >= guide_idle_w) ? IRR_ST_DATA : IRR_ST_G_ACT;
      IRR_ST_DATA:
        nxt_state = IRR_ST_DATA;
    endcase
  end

  // clearing run always returns to stop
  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in || !run)
      state_ff <= IRR_ST_STOP;
    else
      state_ff <= nxt_state;
  end

  // each active pulse in the data state is classed against the zero and one widths
  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in || !run)
    begin
      bit_valid_ff <= 1'b0;
      bit_value_ff <= 1'b0;
      bit_err_ff <= 1'b0;
    end
    else if (state_ff == IRR_ST_DATA && fall)
    begin
      bit_valid_ff <= 1'b1;
      bit_value_ff <= width >= one_w;
      bit_err_ff <= width < zero_w;
    end
  end

  // ********************************************************
  // interrupt, wake and outputs
  // ********************************************************

  // in crystal hold, wake only counts if the receive began on the subclock
  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in || !run)
      sub_start_ff <= 1'b0;
    else if (start)
      sub_start_ff <= (ck_sel == IRR_CK_SUB);
  end

  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in)
    begin
      irq_ff <= 1'b0;
      wake_ff <= 1'b0;
    end
    else
    begin
      irq_ff <= guide_ok_ff && guide_ie_ff;
      wake_ff <= guide_ok_ff && guide_ie_ff && (!xtal_hold_in || sub_start_ff);
    end
  end

  assign prdata_out = prdata_ff;
  assign pready_out = pready_ff;
  assign pslverr_out = pslverr_ff;
  assign irq_out = irq_ff;
  assign hold_release_out = wake_ff;
  assign load_direction_out = high_w_ff[6];

  // ********************************************************
  // checks
  // ********************************************************
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);

  sequence run_clear_s;
    wr_en && idx == IRR_IDX_CONTROL && !pwdata_in[IRR_RUN_BIT];
  endsequence

  sequence stopped_s;
    state_ff == IRR_ST_STOP ##1 state_ff == IRR_ST_STOP;
  endsequence

  // control lands one edge after the write, the state one edge later
  run_stop_a: assert property (run_clear_s |=> ##1 stopped_s)
    else $error("receiver kept running after run cleared");
  no_guide_a: assert property (!irr_has_guide(fmt) |-> !guide_set)
    else $error("guide flagged in a guide-less format");
  flag_sticky_a: assert property (guide_ok_ff && !gok_wr0 |=> guide_ok_ff)
    else $error("guide flag dropped without a clear");
  set_wins_a: assert property (guide_set && gok_wr0 |=> guide_ok_ff)
    else $error("guide flag lost to a clear");
  irq_follow_a: assert property (##1 irq_out == $past(guide_ok_ff && guide_ie_ff))
    else $error("interrupt request out of step with flag");
  hold_gate_a: assert property (xtal_hold_in && ck_sel != IRR_CK_SUB |-> !base_tick)
    else $error("base clock ran in hold without subclock");
  wake_gate_a: assert property (xtal_hold_in && !sub_start_ff ##1 xtal_hold_in |-> !wake_ff)
    else $error("wake raised without a subclock start");
  start_edge_a: assert property (start && active |-> rise)
    else $error("active input at start not taken as edge");
  div_rate_a: assert property (run && !xtal_hold_in && ck_sel == 3'h0 && base_tick
    |=> !base_tick [*3])
    else $error("base clock faster than four cycles");

endmodule
`default_nettype wire

// File: verif/irr_remote_model.sv
// infrared module model: turns a burst request into the demodulated pin level
// assumes bench requests change just after a rising clock edge
`timescale 1ns/1ps
`default_nettype none
module irr_remote_model
  import irr_pkg::*;
(
  // clock
  input wire logic clock_in,
  // burst request and output phase
  input wire logic burst_in,
  input wire logic invert_in,
  // demodulated signal to the receiver pin
  output logic signal_out
);
  // ********
  // output stage
  // ********
  // one cycle of module delay; a negative phase module idles high
  always_ff @(posedge clock_in)
  begin
    signal_out <= burst_in ^ invert_in;
  end
endmodule
`default_nettype wire

// File: verif/test_ir_remote_receiver_front_end.sv
// bench for the remote receiver front end: apb tasks and guide scenarios
// assumes irr_receiver as device and irr_remote_model on its pin
`timescale 1ns/1ps
`default_nettype none
module test_ir_remote_receiver_front_end
  import irr_pkg::*;
;
  // ********
  // clock, reset and wiring
  // ********
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [IRR_ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready, pslverr, remote_pin, irq, hold_rel, load_dir;
  logic burst = 1'h0, invert = 1'h0, xtal_hold = 1'h0, subclock = 1'h0;
  int mismatches = 0, checks = 0, cyc = 0;

  always #5 clk = ~clk;

  irr_receiver dut_u (.clock_in(clk), .sys_rst_in(rst), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .remote_pin_in(remote_pin), .subclock_in(subclock), .xtal_hold_in(xtal_hold),
    .irq_out(irq), .hold_release_out(hold_rel), .load_direction_out(load_dir));
  irr_remote_model ir_u (.clock_in(clk), .burst_in(burst), .invert_in(invert),
    .signal_out(remote_pin));

  // slow subclock from the cycle count; the count also cuts a hang short
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    subclock <= cyc[3];
    if (cyc == 40000)
    begin
      mismatches++;
      summarize();
    end
  end

  // ********
  // shared tasks
  // ********
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one apb transfer; no wait count assumed, only the timeout ends it
  task automatic apb(input logic wr, input logic [15:0] idx, input logic [7:0] wd,
                     output logic [7:0] rd, output logic err);
    @(posedge clk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= {idx, 2'h0};
    pwdata <= {24'h0, wd};
    @(posedge clk);
    penable <= 1'h1;
    @(posedge clk);
    while (pready !== 1'h1)
      @(posedge clk);
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    logic [7:0] rd;
    logic err;
    apb(1'h1, idx, d, rd, err);
  endtask

  task automatic rd_chk(input string what, input logic [15:0] idx, input logic [7:0] exp);
    logic [7:0] rd;
    logic err;
    apb(1'h0, idx, 8'h0, rd, err);
    chk(what, exp, rd);
  endtask

  // bursts of len cycles; the gap scales so slow base clocks settle
  task automatic pulses(input int len, input int n);
    repeat (n)
    begin
      burst <= 1'h1;
      repeat (len) @(posedge clk);
      burst <= 1'h0;
      repeat (len + 40) @(posedge clk);
    end
  endtask

  // setup only while stopped, then start and send bursts
  task automatic guide_run(input logic [7:0] ctl, input logic [7:0] pre,
                           input logic [7:0] gw, input int len, input int n,
                           input logic [7:0] exp);
    wr(IRR_IDX_CONTROL, 8'h00);
    wr(IRR_IDX_INTERRUPT, 8'h00);
    wr(IRR_IDX_PRESCALE, pre);
    wr(IRR_IDX_GUIDE_W, gw);
    wr(IRR_IDX_CONTROL, ctl);
    pulses(len, n);
    rd_chk("guide flag", IRR_IDX_INTERRUPT, exp);
  endtask

  // ********
  // scenarios
  // ********
  task automatic test_regs();
    logic [7:0] rd;
    logic err;
    rd_chk("control reset", IRR_IDX_CONTROL, 8'h00);
    rd_chk("interrupt reset", IRR_IDX_INTERRUPT, 8'h00);
    wr(IRR_IDX_CONTROL, 8'h4f);
    rd_chk("control", IRR_IDX_CONTROL, 8'h4f);
    wr(IRR_IDX_HIGH_W, 8'hff);
    rd_chk("high bits", IRR_IDX_HIGH_W, 8'hbf);
    chk("load direction", 8'h01, {7'h0, load_dir});
    wr(IRR_IDX_HIGH_W, 8'h00);
    wr(IRR_IDX_ZERO_W, 8'h5a);
    rd_chk("zero width", IRR_IDX_ZERO_W, 8'h5a);
    wr(IRR_IDX_ONE_W, 8'ha5);
    rd_chk("one width", IRR_IDX_ONE_W, 8'ha5);
    apb(1'h0, 16'hfec9, 8'h00, rd, err);
    chk("unmapped error", 8'h01, {7'h0, err});
  endtask

  // guide width 3 steps: ppm steps every 4 ticks, manchester every 2
  task automatic test_guide();
    guide_run(8'h87, 8'h00, 8'h00, 3, 1, 8'h00);
    guide_run(8'h07, 8'h00, 8'h00, 24, 1, 8'h00);
    guide_run(8'h87, 8'h00, 8'h30, 6, 1, 8'h00);
    guide_run(8'h87, 8'h00, 8'h30, 24, 1, 8'h80);
    guide_run(8'h80, 8'h00, 8'h30, 80, 1, 8'h80);
    guide_run(8'h87, 8'hc0, 8'h30, 24, 1, 8'h00);
    guide_run(8'h97, 8'h00, 8'h30, 7, 2, 8'h00);
    guide_run(8'h97, 8'h00, 8'h30, 24, 2, 8'h80);
    guide_run(8'hc7, 8'h00, 8'h30, 9, 2, 8'h80);
    guide_run(8'ha7, 8'h00, 8'h30, 24, 2, 8'h00);
    guide_run(8'hb7, 8'h00, 8'h30, 24, 2, 8'h00);
  endtask

  // negative phase input already active when the run bit is set
  task automatic test_start();
    wr(IRR_IDX_CONTROL, 8'h08);
    wr(IRR_IDX_INTERRUPT, 8'h00);
    wr(IRR_IDX_GUIDE_W, 8'h00);
    invert <= 1'h1;
    burst <= 1'h1;
    repeat (8) @(posedge clk);
    wr(IRR_IDX_CONTROL, 8'h8f);
    repeat (20) @(posedge clk);
    burst <= 1'h0;
    repeat (40) @(posedge clk);
    rd_chk("start edge", IRR_IDX_INTERRUPT, 8'h80);
    wr(IRR_IDX_CONTROL, 8'h08);
    invert <= 1'h0;
  endtask

  task automatic test_irq();
    guide_run(8'h87, 8'h00, 8'h00, 8, 1, 8'h80);
    wr(IRR_IDX_INTERRUPT, 8'hc0);
    rd_chk("flag kept", IRR_IDX_INTERRUPT, 8'hc0);
    chk("irq", 8'h01, {7'h0, irq});
    chk("wake", 8'h01, {7'h0, hold_rel});
    xtal_hold <= 1'h1;
    repeat (3) @(posedge clk);
    chk("wake in hold", 8'h00, {7'h0, hold_rel});
    guide_run(8'h87, 8'h00, 8'h00, 8, 1, 8'h00);
    xtal_hold <= 1'h0;
    guide_run(8'h86, 8'h00, 8'h00, 160, 1, 8'h80);
    wr(IRR_IDX_INTERRUPT, 8'hc0);
    xtal_hold <= 1'h1;
    repeat (3) @(posedge clk);
    chk("sub wake", 8'h01, {7'h0, hold_rel});
    xtal_hold <= 1'h0;
    wr(IRR_IDX_INTERRUPT, 8'h40);
    rd_chk("flag cleared", IRR_IDX_INTERRUPT, 8'h40);
    chk("irq off", 8'h00, {7'h0, irq});
  endtask

  // ********
  // main sequence
  // ********
  initial
  begin
    repeat (5) @(posedge clk);
    rst <= 1'h0;
    test_regs();
    test_guide();
    test_start();
    test_irq();
    summarize();
  end
endmodule
`default_nettype wire
